// File: common/irq_regs_pkg.sv
// constants and state types for the button and power-state interrupt block
// Contract
// R1: set hold_long4_flag, status bit 4, after button held over four seconds.
// R2: set hold_long8_flag, status bit 5, after button held over eight seconds.
// R3: status bits read one after their event and stay set until cleared.
// R4: host clears a status bit by reading it or writing one there.
// R5: button mask holds bits 0 to 5, each resetting to one.
// R6: mask bit zero lets a set status bit pull the interrupt low.
// R7: mask bit one blocks the interrupt but status is still recorded.
// R8: push_level_sense is the debounced level, one while pushed, tunable.
// R9: one-second sense reads one while held over a second, zero on release.
// R10: bits 7 and 6 of the sense register are unused, read zero.
// R11: status bit 0 of power-state register sets on completed wake transition.
// R12: status bit 1 of power-state register sets on completed doze transition.
// R13: status bit 2 sets on power-on button event, cleared like others.
// R14: push_change_flag sets on every change of debounced push sense.
// R15: button status bits 1 to 3 set after one, two, three second holds.
// R16: interrupt is low while any unmasked status bit is set, else released.
package irq_regs_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] BTN_STAT_ADDR = 8'h24;
    localparam logic [7:0] BTN_MASK_ADDR = 8'h25;
    localparam logic [7:0] BTN_SENSE_ADDR = 8'h26;
    localparam logic [7:0] PWR_STAT_ADDR = 8'h28;
    localparam logic [7:0] PWR_MASK_ADDR = 8'h29;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

    // ---------------------------------------------------------------
    // field positions and widths
    // ---------------------------------------------------------------
    localparam int BTN_BITS = 6;
    localparam int PWR_BITS = 3;
    localparam int PUSH_BIT = 0;
    localparam int HOLD1_BIT = 1;
    localparam int HOLD2_BIT = 2;
    localparam int HOLD3_BIT = 3;
    localparam int HOLD4_BIT = 4;
    localparam int HOLD8_BIT = 5;
    localparam int WAKE_BIT = 0;
    localparam int DOZE_BIT = 1;
    localparam int BTN_EVENT_BIT = 2;
    localparam int SENSE_PUSH_BIT = 0;
    localparam int SENSE_HOLD1_BIT = 1;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [5:0] BTN_STAT_RST = 6'h00;
    localparam logic [5:0] BTN_MASK_RST = 6'h3f;
    localparam logic [2:0] PWR_STAT_RST = 3'h0;
    localparam logic [2:0] PWR_MASK_RST = 3'h7;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int HOLD_UNIT_MS = 1000;
    localparam int HOLD_UNIT_CYCLES = HOLD_UNIT_MS * CLK_FREQ_KHZ;
    localparam logic [3:0] HOLD1_SECS = 4'h1;
    localparam logic [3:0] HOLD2_SECS = 4'h2;
    localparam logic [3:0] HOLD3_SECS = 4'h3;
    localparam logic [3:0] HOLD4_SECS = 4'h4;
    localparam logic [3:0] HOLD8_SECS = 4'h8;
    localparam int DEB_CNT_W = 16;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        HOLD_IDLE = 2'b01,
        HOLD_RUN = 2'b10
    } hold_state_t;

    typedef struct packed {
        hold_state_t hold_st;
        logic [5:0] btn_stat;
        logic [5:0] btn_mask;
        logic [2:0] pwr_stat;
        logic [2:0] pwr_mask;
        logic push_prev;
        logic [31:0] cyc_cnt;
        logic [3:0] secs;
        logic [7:0] rdata;
        logic rvalid;
        logic irq_oe;
        logic irq_out;
    } top_state_t;

endpackage : irq_regs_pkg

// File: verilog/push_debounce.sv
// debounce filter with separate press and release thresholds
`timescale 1ns/100ps
module push_debounce #(
    parameter int CNT_W = irq_regs_pkg::DEB_CNT_W
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic raw_i,
    input wire logic [CNT_W-1:0] press_cycles_i,
    input wire logic [CNT_W-1:0] release_cycles_i,
    output logic level_o
);

    typedef struct packed {
        logic level;
        logic [CNT_W-1:0] cnt;
    } deb_state_t;

    deb_state_t s_q;
    deb_state_t s_d;
    logic [CNT_W-1:0] thr;

    // ---------------------------------------------------------------
    // filter
    // ---------------------------------------------------------------
    // the level flips after threshold+1 cycles of steady disagreement;
    // any bounce back restarts the count
    always_comb
    begin
        s_d = s_q;
        thr = s_q.level ? release_cycles_i : press_cycles_i;
        if (raw_i != s_q.level)
        begin
            if (s_q.cnt >= thr)
            begin
                s_d.level = raw_i;
                s_d.cnt = '0;
            end
            else
            begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
        else
        begin
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.level;

    chk_deb_follows_raw: assert property ( // see R8
        @(posedge clk_i) disable iff (!resetn_i)
        (s_q.level != $past(s_q.level)) |-> ($past(raw_i) == s_q.level))
        else $error("debounced level moved away from raw input");

endmodule : push_debounce

// File: verilog/power_key_misc_irq_regs.sv
// button and power-state interrupt status, mask and sense registers
`timescale 1ns/100ps
module power_key_misc_irq_regs #(
    parameter int SECOND_CYCLES = irq_regs_pkg::HOLD_UNIT_CYCLES,
    parameter int DEB_W = irq_regs_pkg::DEB_CNT_W
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic POWER_PUSH_BUTTON_N_I,
    input wire logic [DEB_W-1:0] DEB_PRESS_CYCLES_I,
    input wire logic [DEB_W-1:0] DEB_RELEASE_CYCLES_I,
    input wire logic WAKE_DONE_I,
    input wire logic DOZE_DONE_I,
    input wire logic BUTTON_EVENT_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    output logic IRQ_OUT_N_O,
    output logic IRQ_OUT_N_OE_O
);

    irq_regs_pkg::top_state_t s_q;
    irq_regs_pkg::top_state_t s_d;

    logic push_lvl;
    logic hold_tick;
    logic [3:0] secs_next;
    logic [5:0] btn_set;
    logic [2:0] pwr_set;
    logic [5:0] btn_clr;
    logic [2:0] pwr_clr;
    logic [7:0] sense_val;
    logic hold1_sense;

    // ---------------------------------------------------------------
    // button debounce
    // ---------------------------------------------------------------
    push_debounce #(
        .CNT_W(DEB_W)
    ) u_debounce (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .raw_i(~POWER_PUSH_BUTTON_N_I),
        .press_cycles_i(DEB_PRESS_CYCLES_I),
        .release_cycles_i(DEB_RELEASE_CYCLES_I),
        .level_o(push_lvl)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        btn_set = '0;
        pwr_set = '0;
        btn_clr = '0;
        pwr_clr = '0;
        sense_val = 8'h00;
        hold_tick = 1'b0;
        secs_next = s_q.secs + 4'h1;

        // hold timer: the second counter only runs while pushed and
        // saturates at eight so a stuck button cannot wrap the flags
        case (s_q.hold_st)
            irq_regs_pkg::HOLD_IDLE:
            begin
                s_d.cyc_cnt = '0;
                s_d.secs = '0;
                if (push_lvl)
                begin
                    s_d.hold_st = irq_regs_pkg::HOLD_RUN;
                end
            end
            irq_regs_pkg::HOLD_RUN:
            begin
                if (!push_lvl)
                begin
                    s_d.hold_st = irq_regs_pkg::HOLD_IDLE;
                    s_d.cyc_cnt = '0;
                    s_d.secs = '0;
                end
                else if (s_q.secs != irq_regs_pkg::HOLD8_SECS)
                begin
                    if (s_q.cyc_cnt == 32'(SECOND_CYCLES - 1))
                    begin
                        hold_tick = 1'b1;
                        s_d.cyc_cnt = '0;
                        s_d.secs = secs_next;
                    end
                    else
                    begin
                        s_d.cyc_cnt = s_q.cyc_cnt + 32'h1;
                    end
                end
            end
            default:
            begin
                s_d.hold_st = irq_regs_pkg::HOLD_IDLE;
                s_d.cyc_cnt = '0;
                s_d.secs = '0;
            end
        endcase

        // hold thresholds
        if (hold_tick)
        begin
            btn_set[irq_regs_pkg::HOLD1_BIT] =
                (secs_next == irq_regs_pkg::HOLD1_SECS); // see R15
            btn_set[irq_regs_pkg::HOLD2_BIT] =
                (secs_next == irq_regs_pkg::HOLD2_SECS); // see R15
            btn_set[irq_regs_pkg::HOLD3_BIT] =
                (secs_next == irq_regs_pkg::HOLD3_SECS); // see R15
            btn_set[irq_regs_pkg::HOLD4_BIT] =
                (secs_next == irq_regs_pkg::HOLD4_SECS); // see R1
            btn_set[irq_regs_pkg::HOLD8_BIT] =
                (secs_next == irq_regs_pkg::HOLD8_SECS); // see R2
        end

        // both press and release count as a change
        btn_set[irq_regs_pkg::PUSH_BIT] =
            (push_lvl != s_q.push_prev); // see R14
        s_d.push_prev = push_lvl;

        pwr_set[irq_regs_pkg::WAKE_BIT] = WAKE_DONE_I; // see R11
        pwr_set[irq_regs_pkg::DOZE_BIT] = DOZE_DONE_I; // see R12
        pwr_set[irq_regs_pkg::BTN_EVENT_BIT] = BUTTON_EVENT_I; // see R13

        // read-to-clear takes exactly the bits that were returned
        if (REG_RD_I && REG_ADDR_I == irq_regs_pkg::BTN_STAT_ADDR)
        begin
            btn_clr = s_q.btn_stat; // see R4
        end
        if (REG_RD_I && REG_ADDR_I == irq_regs_pkg::PWR_STAT_ADDR)
        begin
            pwr_clr = s_q.pwr_stat; // see R4
        end
        if (REG_WR_I && REG_ADDR_I == irq_regs_pkg::BTN_STAT_ADDR)
        begin
            btn_clr = btn_clr | REG_WDATA_I[5:0]; // see R4
        end
        if (REG_WR_I && REG_ADDR_I == irq_regs_pkg::PWR_STAT_ADDR)
        begin
            pwr_clr = pwr_clr | REG_WDATA_I[2:0]; // see R4
        end

        // a set in the clear cycle survives
        s_d.btn_stat = (s_q.btn_stat & ~btn_clr) | btn_set; // see R3
        s_d.pwr_stat = (s_q.pwr_stat & ~pwr_clr) | pwr_set; // see R3

        if (REG_WR_I && REG_ADDR_I == irq_regs_pkg::BTN_MASK_ADDR)
        begin
            s_d.btn_mask = REG_WDATA_I[5:0]; // see R5
        end
        if (REG_WR_I && REG_ADDR_I == irq_regs_pkg::PWR_MASK_ADDR)
        begin
            s_d.pwr_mask = REG_WDATA_I[2:0];
        end

        // sense register; upper bits stay zero
        hold1_sense = push_lvl && (s_q.hold_st == irq_regs_pkg::HOLD_RUN) &&
            (s_q.secs >= irq_regs_pkg::HOLD1_SECS); // see R9
        sense_val[irq_regs_pkg::SENSE_PUSH_BIT] = push_lvl; // see R8
        sense_val[irq_regs_pkg::SENSE_HOLD1_BIT] = hold1_sense; // see R9, R10

        // read port
        s_d.rvalid = REG_RD_I;
        if (REG_RD_I)
        begin
            case (REG_ADDR_I)
                irq_regs_pkg::BTN_STAT_ADDR:
                    s_d.rdata = {2'b00, s_q.btn_stat};
                irq_regs_pkg::BTN_MASK_ADDR:
                    s_d.rdata = {2'b00, s_q.btn_mask};
                irq_regs_pkg::BTN_SENSE_ADDR:
                    s_d.rdata = sense_val;
                irq_regs_pkg::PWR_STAT_ADDR:
                    s_d.rdata = {5'h00, s_q.pwr_stat};
                irq_regs_pkg::PWR_MASK_ADDR:
                    s_d.rdata = {5'h00, s_q.pwr_mask};
                default:
                    s_d.rdata = irq_regs_pkg::UNMAPPED_RDATA;
            endcase
        end

        // open-drain output: level is always low, only the enable moves
        s_d.irq_out = 1'b0;
        s_d.irq_oe = (|(s_d.btn_stat & ~s_d.btn_mask)) ||
            (|(s_d.pwr_stat & ~s_d.pwr_mask)); // see R6, R7, R16
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            s_q.hold_st <= irq_regs_pkg::HOLD_IDLE;
            s_q.btn_stat <= irq_regs_pkg::BTN_STAT_RST;
            s_q.btn_mask <= irq_regs_pkg::BTN_MASK_RST; // see R5
            s_q.pwr_stat <= irq_regs_pkg::PWR_STAT_RST;
            s_q.pwr_mask <= irq_regs_pkg::PWR_MASK_RST;
            s_q.push_prev <= 1'b0;
            s_q.cyc_cnt <= '0;
            s_q.secs <= '0;
            s_q.rdata <= 8'h00;
            s_q.rvalid <= 1'b0;
            s_q.irq_oe <= 1'b0;
            s_q.irq_out <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign REG_RDATA_O = s_q.rdata;
    assign REG_RVALID_O = s_q.rvalid;
    assign IRQ_OUT_N_O = s_q.irq_out;
    assign IRQ_OUT_N_OE_O = s_q.irq_oe;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_irq_pending_map: assert property ( // see R16
        @(posedge CLK_I) disable iff (!RESETN_I)
        IRQ_OUT_N_OE_O == ((|(s_q.btn_stat & ~s_q.btn_mask)) ||
            (|(s_q.pwr_stat & ~s_q.pwr_mask))))
        else $error("interrupt enable disagrees with pending bits");

    chk_masked_quiet: assert property ( // see R7
        @(posedge CLK_I) disable iff (!RESETN_I)
        (s_q.btn_mask == 6'h3f && s_q.pwr_mask == 3'h7) |-> !IRQ_OUT_N_OE_O)
        else $error("interrupt asserted with every bit masked");

    chk_status_sticky: assert property ( // see R3
        @(posedge CLK_I) disable iff (!RESETN_I)
        (s_q.btn_stat[irq_regs_pkg::HOLD4_BIT] && !REG_RD_I && !REG_WR_I)
        |=> s_q.btn_stat[irq_regs_pkg::HOLD4_BIT])
        else $error("status bit dropped without a clear");

    chk_w1c_clears: assert property ( // see R4
        @(posedge CLK_I) disable iff (!RESETN_I)
        (REG_WR_I && REG_ADDR_I == irq_regs_pkg::PWR_STAT_ADDR &&
            REG_WDATA_I[irq_regs_pkg::WAKE_BIT] && !WAKE_DONE_I)
        |=> !s_q.pwr_stat[irq_regs_pkg::WAKE_BIT])
        else $error("write one did not clear status bit");

    chk_read_clears: assert property ( // see R4
        @(posedge CLK_I) disable iff (!RESETN_I)
        (REG_RD_I && REG_ADDR_I == irq_regs_pkg::PWR_STAT_ADDR && !DOZE_DONE_I)
        |=> (!s_q.pwr_stat[irq_regs_pkg::DOZE_BIT] &&
            REG_RVALID_O && REG_RDATA_O[7:3] == 5'h00))
        else $error("read did not clear status or return data");

    chk_event_sets: assert property ( // see R11, R12, R13
        @(posedge CLK_I) disable iff (!RESETN_I)
        (WAKE_DONE_I || DOZE_DONE_I || BUTTON_EVENT_I) |=>
        (s_q.pwr_stat & $past({BUTTON_EVENT_I, DOZE_DONE_I, WAKE_DONE_I}))
            == $past({BUTTON_EVENT_I, DOZE_DONE_I, WAKE_DONE_I}))
        else $error("power-state event not recorded");

    chk_push_change: assert property ( // see R14
        @(posedge CLK_I) disable iff (!RESETN_I)
        (push_lvl != s_q.push_prev) |=> s_q.btn_stat[irq_regs_pkg::PUSH_BIT])
        else $error("push change not recorded");

    chk_hold4_flag: assert property ( // see R1
        @(posedge CLK_I) disable iff (!RESETN_I)
        (s_q.secs == irq_regs_pkg::HOLD4_SECS &&
            $past(s_q.secs) == irq_regs_pkg::HOLD3_SECS)
        |-> s_q.btn_stat[irq_regs_pkg::HOLD4_BIT])
        else $error("four second hold flag missing");

    chk_hold8_flag: assert property ( // see R2
        @(posedge CLK_I) disable iff (!RESETN_I)
        $rose(s_q.secs == irq_regs_pkg::HOLD8_SECS)
        |-> s_q.btn_stat[irq_regs_pkg::HOLD8_BIT])
        else $error("eight second hold flag missing");

    chk_sense_release: assert property ( // see R9
        @(posedge CLK_I) disable iff (!RESETN_I)
        (REG_RD_I && REG_ADDR_I == irq_regs_pkg::BTN_SENSE_ADDR && !push_lvl)
        |=> (REG_RDATA_O[1:0] == 2'b00 && REG_RDATA_O[7:6] == 2'b00))
        else $error("sense bits set with button released");

    chk_hold1_flag: assert property ( // see R15
        @(posedge CLK_I) disable iff (!RESETN_I)
        (s_q.secs == irq_regs_pkg::HOLD1_SECS &&
            $past(s_q.secs) == 4'h0)
        |-> s_q.btn_stat[irq_regs_pkg::HOLD1_BIT])
        else $error("one second hold flag missing");

    chk_sense_push: assert property ( // see R8
        @(posedge CLK_I) disable iff (!RESETN_I)
        (REG_RD_I && REG_ADDR_I == irq_regs_pkg::BTN_SENSE_ADDR)
        |=> (REG_RDATA_O[irq_regs_pkg::SENSE_PUSH_BIT] == $past(push_lvl)))
        else $error("sense push bit disagrees with debounced level");

    chk_secs_capped: assert property ( // see R2
        @(posedge CLK_I) disable iff (!RESETN_I)
        s_q.secs <= irq_regs_pkg::HOLD8_SECS)
        else $error("hold second count passed eight");

endmodule : power_key_misc_irq_regs

// File: tb/host_reg_master.sv
// host side model: byte register reads and writes on the strobe port
`timescale 1ns/100ps
module host_reg_master (
    input wire logic clk_i,
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    initial
    begin
        addr_o = 8'h5a;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'ha5;
    end

    // ---------------------------------------------------------------
    // bus cycles
    // ---------------------------------------------------------------
    // released lines show the inverse so a stale value is never reused
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
    endtask : read_reg
endmodule : host_reg_master

// File: tb/power_key_misc_irq_regs_tb.sv
// self-checking bench for the button and power-state interrupt block
`timescale 1ns/100ps
module power_key_misc_irq_regs_tb;
    localparam int SEC = 20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic btn_n = 1'b1;
    logic [2:0] pwr_ev = 3'h0;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic irq_n;
    logic irq_oe;
    wire logic irq_pin;
    logic [7:0] expq[$];
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] m;

    always #4 clk = ~clk;
    // open-drain pin with pull-up
    assign irq_pin = irq_oe ? irq_n : 1'b1;

    host_reg_master host_u (
        .clk_i(clk),
        .addr_o(addr),
        .wr_o(wr),
        .rd_o(rd),
        .wdata_o(wdata)
    );

    power_key_misc_irq_regs #(
        .SECOND_CYCLES(SEC)
    ) dut_u (
        .CLK_I(clk),
        .RESETN_I(resetn),
        .POWER_PUSH_BUTTON_N_I(btn_n),
        .DEB_PRESS_CYCLES_I(16'h0002),
        .DEB_RELEASE_CYCLES_I(16'h0005),
        .WAKE_DONE_I(pwr_ev[0]),
        .DOZE_DONE_I(pwr_ev[1]),
        .BUTTON_EVENT_I(pwr_ev[2]),
        .REG_ADDR_I(addr),
        .REG_WR_I(wr),
        .REG_RD_I(rd),
        .REG_WDATA_I(wdata),
        .REG_RDATA_O(rdata),
        .REG_RVALID_O(rvalid),
        .IRQ_OUT_N_O(irq_n),
        .IRQ_OUT_N_OE_O(irq_oe)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        host_u.read_reg(a);
        cyc(2);
    endtask : rd_exp

    task automatic pin_is(input logic e);
        cyc(3);
        chk("irq_pin", {7'h00, e}, {7'h00, irq_pin});
    endtask : pin_is

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // ---------------------------------------------------------------
    // read data monitor
    // ---------------------------------------------------------------
    always @(negedge clk)
    begin
        if (rvalid === 1'b1)
        begin
            if (expq.size() == 0)
                chk("unexpected_read", 8'h00, 8'hff);
            else
                chk("read_data", expq.pop_front(), rdata);
        end
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hd332));
        cyc(16);
        resetn <= 1'b1;
        cyc(2);
        pin_is(1'b1);
        rd_exp(8'h24, 8'h00);
        rd_exp(8'h25, 8'h3f);
        rd_exp(8'h26, 8'h00);
        rd_exp(8'h28, 8'h00);
        rd_exp(8'h29, 8'h07);
        // long hold: early flags at 3.5 s, late ones after 8 s
        btn_n <= 1'b0;
        cyc(10);
        rd_exp(8'h26, 8'h01);
        cyc(58);
        rd_exp(8'h24, 8'h0f);
        rd_exp(8'h26, 8'h03);
        cyc(110);
        rd_exp(8'h24, 8'h30);
        rd_exp(8'h24, 8'h00);
        btn_n <= 1'b1;
        cyc(2);
        rd_exp(8'h26, 8'h03);
        cyc(6);
        rd_exp(8'h26, 8'h00);
        pin_is(1'b1);
        host_u.write_reg(8'h25, 8'h3e);
        pin_is(1'b0);
        host_u.write_reg(8'h24, 8'h01);
        pin_is(1'b1);
        rd_exp(8'h24, 8'h00);
        // power-state events, the first cleared by a write, the other two by reads
        host_u.write_reg(8'h25, 8'h3f);
        host_u.write_reg(8'h29, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            pwr_ev <= 3'h1 << i;
            @(posedge clk);
            pwr_ev <= 3'h0;
            pin_is(1'b0);
            if (i == 0)
                host_u.write_reg(8'h28, 8'h01);
            else
                rd_exp(8'h28, 8'h01 << i);
            pin_is(1'b1);
        end
        rd_exp(8'h28, 8'h00);
        // short glitch below debounce leaves the flags alone
        @(posedge clk);
        btn_n <= 1'b0;
        @(posedge clk);
        btn_n <= 1'b1;
        cyc(8);
        rd_exp(8'h24, 8'h00);
        // random masks, read-only and unmapped places
        for (int i = 0; i < 4; i++)
        begin
            m = 8'($urandom());
            host_u.write_reg(8'h25, m);
            rd_exp(8'h25, m & 8'h3f);
            host_u.write_reg(8'h26, m);
            rd_exp(8'h26, 8'h00);
            host_u.write_reg(8'h30, m);
            rd_exp(8'h30, 8'h00);
        end
        cyc(10);
        chk("pending_reads", 8'h00, 8'(expq.size()));
        print_verdict();
    end
endmodule : power_key_misc_irq_regs_tb
